//--- rtl/sei_error_reporter.sv
// System-error reporting logic of a bus agent.
// Assumes error events are one-cycle pulses synchronous to clk,
// and the open-drain line is resolved outside with a pull-up.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "sei_consts.svh"
module sei_error_reporter (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic addrParityErr,
   input wire logic selectedTarget,
   input wire logic specialCycleParityErr,
   input wire logic masterParityErr,
   input wire logic masterParityReported,
   input wire logic abnormalTermination,
   input wire logic masterHasDriver,
   input wire logic configOrSpecialMasterAbort,
   input wire logic targetAbortAsMaster,
   input wire logic catastrophicErr,
   input wire logic system_error_n_in,
   output logic system_error_n_out,
   output logic system_error_n_oe,
   output sei_pkg::sei_resp_t targetResponse,
   output logic irq
);
   logic [1:0] cmd_reg;
   logic [31:0] rdata_reg;
   logic [`SEI_EV_WIDTH-1:0] pend_reg;
   logic driving_reg;
   sei_pkg::sei_resp_t resp_reg;
   logic perEn;
   logic serrEn;
   logic parityEvent;
   logic [`SEI_EV_WIDTH-1:0] evRaw;
   logic [`SEI_EV_WIDTH-1:0] evAllowed;
   logic [`SEI_EV_WIDTH-1:0] irqStat;
   logic [`SEI_EV_WIDTH-1:0] irqEn_reg;
   logic perrDetected;
   logic sseFlag;
   logic lineIdle;
   logic wrStatus;
   logic wrIrqClr;
   logic fire;
   logic abortReportable;

   assign perEn = cmd_reg[`SEI_CMD_PER_BIT];
   assign serrEn = cmd_reg[`SEI_CMD_SERR_BIT];

   // Abnormal ends only count for a driverless master, never the benign master-aborts
   assign abortReportable = !masterHasDriver && !configOrSpecialMasterAbort;

   // Any agent checks address parity, not just master or target
   assign evRaw[`SEI_EV_ADDR_PAR] = addrParityErr;
   assign evRaw[`SEI_EV_SPC_PAR] = specialCycleParityErr;
   assign evRaw[`SEI_EV_MST_PAR] = masterParityErr && !masterParityReported;
   assign evRaw[`SEI_EV_ABORT] = (abnormalTermination || targetAbortAsMaster) && abortReportable;
   assign evRaw[`SEI_EV_FATAL] = catastrophicErr;

   assign parityEvent = addrParityErr || specialCycleParityErr || masterParityErr;

   // Parity cases need both enables; the rest need only the system-error enable
   assign evAllowed[`SEI_EV_ADDR_PAR] = evRaw[`SEI_EV_ADDR_PAR] && perEn && serrEn;
   assign evAllowed[`SEI_EV_SPC_PAR] = evRaw[`SEI_EV_SPC_PAR] && perEn && serrEn;
   assign evAllowed[`SEI_EV_MST_PAR] = evRaw[`SEI_EV_MST_PAR] && perEn && serrEn;
   assign evAllowed[`SEI_EV_ABORT] = evRaw[`SEI_EV_ABORT] && serrEn;
   assign evAllowed[`SEI_EV_FATAL] = evRaw[`SEI_EV_FATAL] && serrEn;

   assign wrStatus = regWrite && (regAddr == `SEI_ADDR_STATUS);
   assign wrIrqClr = regWrite && (regAddr == `SEI_ADDR_IRQ_CLR);

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd_reg <= `SEI_CMD_RESET;
      end else if (ce && regWrite && regAddr == `SEI_ADDR_CMD) begin
         cmd_reg <= regWdata[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irqEn_reg <= '0;
      end else if (ce && regWrite && regAddr == `SEI_ADDR_IRQ_EN) begin
         irqEn_reg <= regWdata[`SEI_EV_WIDTH-1:0];
      end
   end

   // Isolates the lowest pending bit so kinds are served in a fixed order
   function automatic logic [`SEI_EV_WIDTH-1:0] lowestPend(input logic [`SEI_EV_WIDTH-1:0] p);
      lowestPend = p & (~p + `SEI_EV_WIDTH'(1));
   endfunction : lowestPend

   // Pending event kinds queue up so each kind gets its own pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         pend_reg <= '0;
      end else if (ce) begin
         if (!serrEn) begin
            pend_reg <= '0;
         end else begin
            pend_reg <= (pend_reg & ~({`SEI_EV_WIDTH{fire}} & lowestPend(pend_reg))) | evAllowed;
         end
      end
   end

   // A new pulse only after the line reads released twice, else pulses merge
   assign fire = serrEn && (pend_reg != '0) && !driving_reg && lineIdle;

   always_ff @(posedge clk) begin
      if (rst) begin
         driving_reg <= 1'b0;
      end else if (ce) begin
         driving_reg <= fire;
      end
   end

   // Active-low drive enable; data always low for open drain
   assign system_error_n_out = 1'b0;
   assign system_error_n_oe = !driving_reg;

   sei_line_monitor u_mon (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .lineIn(system_error_n_in),
      .lineIdle(lineIdle)
   );

   sei_sticky u_perr (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .setIn(parityEvent),
      .clrIn(wrStatus && regWdata[`SEI_ST_PERR_BIT]),
      .flagOut(perrDetected)
   );

   sei_sticky u_sse (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .setIn(fire),
      .clrIn(wrStatus && regWdata[`SEI_ST_SSE_BIT]),
      .flagOut(sseFlag)
   );

   genvar gi;
   generate
      for (gi = 0; gi < `SEI_EV_WIDTH; gi++) begin : gIrq
         sei_sticky u_ev (
            .clk(clk),
            .rst(rst),
            .ce(ce),
            .setIn(evRaw[gi]),
            .clrIn(wrIrqClr && regWdata[gi]),
            .flagOut(irqStat[gi])
         );
      end
   endgenerate

   // Non-NMI path for errors software may want without the line
   assign irq = |(irqStat & irqEn_reg);

   // Selected target answers address parity with target-abort if parity response is on, else no claim; never retry
   always_ff @(posedge clk) begin
      if (rst) begin
         resp_reg <= sei_pkg::SEI_RESP_NONE;
      end else if (ce) begin
         if (addrParityErr && selectedTarget) begin
            resp_reg <= perEn ? sei_pkg::SEI_RESP_TARGET_ABORT : sei_pkg::SEI_RESP_NO_CLAIM;
         end else begin
            resp_reg <= sei_pkg::SEI_RESP_NONE;
         end
      end
   end
   assign targetResponse = resp_reg;

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (ce) begin
         if (!regRead) begin
            rdata_reg <= 32'h0000_0000;
         end else if (regAddr == `SEI_ADDR_CMD) begin
            rdata_reg <= {30'h0, cmd_reg};
         end else if (regAddr == `SEI_ADDR_STATUS) begin
            rdata_reg <= {29'h0, lineIdle, sseFlag, perrDetected};
         end else if (regAddr == `SEI_ADDR_IRQ_STAT) begin
            rdata_reg <= {27'h0, irqStat};
         end else if (regAddr == `SEI_ADDR_IRQ_EN) begin
            rdata_reg <= {27'h0, irqEn_reg};
         end else begin
            rdata_reg <= 32'h0000_0000;
         end
      end
   end
   assign regRdata = rdata_reg;
endmodule : sei_error_reporter

//--- include/sei_consts.svh
// Constants for the system-error reporting block.
// Assumes inclusion by bare name from design files.
//
// Contract
// - Address, special-cycle and non-parity errors use line
// - Any agent checks and signals address parity
// - Never drive line without enable bit
// - Driving line sets signalled-system-error flag
// - Parity errors always set detected flag
// - Target-abort or no claim on address parity
// - No retry or disconnect on address parity
// - Assert within two clocks of detection (code waits longer while the line is not idle or an earlier kind is pending)
// - Drive line only for NMI-safe errors
// - Parity cases need both enable bits
// - Driverless abort or catastrophe need enable only
// - No line for config/special master-abort
// - Only driverless master reports target-abort
// - Line wire-ORed; released needs two high samples
`ifndef SEI_CONSTS_SVH
`define SEI_CONSTS_SVH
`define SEI_ADDR_CMD 4'h0
`define SEI_ADDR_STATUS 4'h1
`define SEI_ADDR_IRQ_STAT 4'h2
`define SEI_ADDR_IRQ_CLR 4'h3
`define SEI_ADDR_IRQ_EN 4'h4
`define SEI_CMD_PER_BIT 0
`define SEI_CMD_SERR_BIT 1
`define SEI_CMD_RESET 2'h0
`define SEI_ST_PERR_BIT 0
`define SEI_ST_SSE_BIT 1
`define SEI_ST_IDLE_BIT 2
`define SEI_EV_WIDTH 5
`define SEI_EV_ADDR_PAR 0
`define SEI_EV_SPC_PAR 1
`define SEI_EV_MST_PAR 2
`define SEI_EV_ABORT 3
`define SEI_EV_FATAL 4
`define SEI_IDLE_SAMPLES 2
`define SEI_LATENCY_CLOCKS 2
`endif

//--- include/sei_pkg.sv
// Types for the system-error reporting block.
// Assumes the constants header is compiled alongside.
package sei_pkg;
   typedef enum logic [1:0] {
      SEI_IDLE,
      SEI_DRIVE,
      SEI_WAIT
   } sei_state_t;
   typedef enum logic [1:0] {
      SEI_RESP_NONE,
      SEI_RESP_TARGET_ABORT,
      SEI_RESP_NO_CLAIM
   } sei_resp_t;
endpackage : sei_pkg

//--- rtl/sei_sticky.sv
// One sticky flag bit: hardware set, software clear.
// Assumes a single clock; set wins over clear.
`timescale 1ns/1ps
module sei_sticky (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic setIn,
   input wire logic clrIn,
   output logic flagOut
);
   always_ff @(posedge clk) begin
      if (rst) begin
         flagOut <= 1'b0;
      end else if (ce) begin
         if (setIn) begin
            flagOut <= 1'b1;
         end else if (clrIn) begin
            flagOut <= 1'b0;
         end
      end
   end
endmodule : sei_sticky

//--- rtl/sei_line_monitor.sv
// Watches the shared system-error line level.
// Assumes the sampled line is synchronous to clk.
`timescale 1ns/1ps
`include "sei_consts.svh"
module sei_line_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic lineIn,
   output logic lineIdle
);
   logic [1:0] highCount_reg;
   // Wire-OR line stays suspect until seen high twice in a row
   always_ff @(posedge clk) begin
      if (rst) begin
         highCount_reg <= 2'h0;
      end else if (ce) begin
         if (!lineIn) begin
            highCount_reg <= 2'h0;
         end else if (highCount_reg != 2'(`SEI_IDLE_SAMPLES)) begin
            highCount_reg <= highCount_reg + 2'h1;
         end
      end
   end
   assign lineIdle = (highCount_reg == 2'(`SEI_IDLE_SAMPLES));
endmodule : sei_line_monitor

//--- bench/sei_host_model.sv
// Central resource: line pull-up and pulse counter.
// Assumes active-low enables from each agent.
`timescale 1ns/1ps
module sei_host_model (
   input wire logic clk,
   input wire logic agentOe,
   input wire logic otherOe,
   output logic lineN,
   output int pulses
);
   logic prevLine = 1'b1;
   // Wire-OR with pull-up: high when nobody drives
   assign lineN = agentOe & otherOe;
   initial pulses = 0;
   always @(posedge clk) begin
      if (prevLine && !lineN) pulses <= pulses + 1;
      prevLine <= lineN;
   end
endmodule : sei_host_model

//--- bench/sei_error_reporter_monitor.sv
// Port checker for the error reporter.
// Assumes ce held high.
`timescale 1ns/1ps
module sei_error_reporter_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic addrParityErr,
   input wire logic selectedTarget,
   input wire logic abnormalTermination,
   input wire logic masterHasDriver,
   input wire logic configOrSpecialMasterAbort,
   input wire logic catastrophicErr,
   input wire logic system_error_n_in,
   input wire logic system_error_n_oe,
   input wire sei_pkg::sei_resp_t targetResponse
);
   logic [1:0] cmdReg;
   wire quiet = system_error_n_oe & system_error_n_in;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Shadow of the command word
   always_ff @(posedge clk) begin
      if (rst) cmdReg <= 2'h0;
      else if (regWrite && regAddr == 4'h0) cmdReg <= regWdata[1:0];
   end
   AST_GATED: assert property (!system_error_n_oe |-> $past(cmdReg[1])) else $error("driven while off");
   AST_ONE_CLK: assert property ($fell(system_error_n_oe) |=> system_error_n_oe) else $error("long pulse");
   AST_ADDR_FAST: assert property (addrParityErr && cmdReg == 2'h3 && quiet && $past(system_error_n_in)
      |-> ##[1:2] !system_error_n_oe) else $error("no address pulse");
   AST_FATAL_FAST: assert property (catastrophicErr && cmdReg[1] && quiet && $past(system_error_n_in)
      |-> ##[1:2] !system_error_n_oe) else $error("no fatal pulse");
   AST_PER_GATE: assert property (addrParityErr && !cmdReg[0] && quiet |=> system_error_n_oe[*3])
      else $error("parity pulse without response");
   AST_NO_ABORT: assert property (abnormalTermination && (masterHasDriver || configOrSpecialMasterAbort)
      && quiet |=> system_error_n_oe[*3]) else $error("recoverable abort pulsed");
   AST_RESP: assert property (addrParityErr && selectedTarget |=> targetResponse == ($past(cmdReg[0]) ?
      sei_pkg::SEI_RESP_TARGET_ABORT : sei_pkg::SEI_RESP_NO_CLAIM)) else $error("bad response");
   AST_NO_RETRY: assert property (targetResponse != sei_pkg::SEI_RESP_NONE
      |-> $past(addrParityErr) && $past(selectedTarget)) else $error("stray response");
   C_PULSE: cover property ($fell(system_error_n_oe));
   C_ABORT: cover property (targetResponse == sei_pkg::SEI_RESP_TARGET_ABORT);
   C_NOCLAIM: cover property (targetResponse == sei_pkg::SEI_RESP_NO_CLAIM);
endmodule : sei_error_reporter_monitor
bind sei_error_reporter sei_error_reporter_monitor sei_error_reporter_monitor_inst (.*);

//--- bench/sei_error_reporter_tb_top.sv
// Bench for the error reporter.
// Assumes one clock; host model resolves the line.
`timescale 1ns/1ps
module sei_error_reporter_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic [31:0] regRdata, rv;
   logic [5:0] ev = 6'h00;
   logic rep = 1'b0, drv = 1'b0, cfg = 1'b0, sel = 1'b1, otherOe = 1'b1;
   logic lineN, oeN, outN, irq;
   sei_pkg::sei_resp_t resp;
   int pulses, p0, n_errors = 0, n_checks = 0;
   // {cmd, reported, driver, cfgAbort, events, pulse}
   logic [11:0] rows [13] = '{12'hC03, 12'h802, 12'h402, 12'hC05, 12'hC09, 12'hE08, 12'h811,
      12'h910, 12'h890, 12'h841, 12'h940, 12'h821, 12'h420};
   always #50 clk = ~clk;
   sei_host_model sei_host_model_inst (.clk(clk), .agentOe(oeN), .otherOe(otherOe), .lineN(lineN), .pulses(pulses));
   sei_error_reporter sei_error_reporter_inst (.clk(clk), .rst(rst), .ce(1'b1), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .addrParityErr(ev[0]),
      .selectedTarget(sel), .specialCycleParityErr(ev[1]), .masterParityErr(ev[2]), .masterParityReported(rep),
      .abnormalTermination(ev[3]), .masterHasDriver(drv), .configOrSpecialMasterAbort(cfg),
      .targetAbortAsMaster(ev[5]), .catastrophicErr(ev[4]), .system_error_n_in(lineN),
      .system_error_n_out(outN), .system_error_n_oe(oeN), .targetResponse(resp), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask : rd
   task automatic fire(input logic [5:0] e);
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= 6'h00;
      #1;
   endtask : fire
   task automatic conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      rd(4'h0, rv);
      chk(rv, 32'h0);
      rd(4'h1, rv);
      chk(rv, 32'h4);
      rd(4'hF, rv);
      chk(rv, 32'h0);
      chk({31'h0, oeN}, 32'h1);
      chk({31'h0, outN}, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         wr(4'h0, {30'h0, rows[i][11:10]});
         p0 = pulses;
         rep <= rows[i][9];
         drv <= rows[i][8];
         cfg <= rows[i][7];
         sel <= ~sel;
         fire(rows[i][6:1]);
         repeat (6) @(posedge clk);
         chk(pulses - p0, {31'h0, rows[i][0]});
         rd(4'h1, rv);
         chk(rv[1:0], {rows[i][0], |rows[i][3:1]});
         wr(4'h1, 32'h3);
         $display("row %0d done", i);
      end
      // Enabled, masked and cleared interrupt; selected target without parity response
      wr(4'h0, 32'h0);
      sel <= 1'b1;
      wr(4'h3, 32'h1F);
      wr(4'h4, 32'h1);
      chk({31'h0, irq}, 32'h0);
      fire(6'h01);
      chk({30'h0, resp}, {30'h0, sei_pkg::SEI_RESP_NO_CLAIM});
      chk({31'h0, irq}, 32'h1);
      wr(4'h4, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(4'h4, 32'h1);
      wr(4'h3, 32'h1);
      chk({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      // Two kinds at once while another agent holds the line low
      wr(4'h0, 32'h3);
      p0 = pulses;
      otherOe <= 1'b0;
      fire(6'h11);
      chk({30'h0, resp}, {30'h0, sei_pkg::SEI_RESP_TARGET_ABORT});
      repeat (3) @(posedge clk);
      otherOe <= 1'b1;
      repeat (14) @(posedge clk);
      chk(pulses - p0, 32'h3);
      $display("queue test done");
      conclude();
   end
endmodule : sei_error_reporter_tb_top
